// [verilog/rtc_core.sv]
// Clock block top: register file over AXI4-Lite, interrupts, divider and square wave.
//
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module rtc_core (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_awaddr,
  // AXI4-Lite write data.
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response.
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [31:0] s_axi_araddr,
  // AXI4-Lite read data.
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Time base and alarm comparator.
  input wire logic time_base_tick,
  input wire logic alarm_match,
  // Pins toward the system.
  output logic irq_n,
  output logic square_wave_out,
  output logic update_in_progress
);
  import rtc_pkg::*;

  // ----------------------------------------------------------------
  // Storage and control registers
  // ----------------------------------------------------------------
  logic [7:0] mem_q [0:RTC_NUM_LOC-1];
  logic [6:0] reg_a_q;
  logic [7:0] reg_b_q;
  logic [2:0] divider_select;
  logic [3:0] rate_select;
  logic update_hold;
  logic square_wave_enable;
  logic [2:0] src_enable;

  // ----------------------------------------------------------------
  // Bus channel state
  // ----------------------------------------------------------------
  logic aw_full_q;
  logic [31:0] aw_addr_q;
  logic w_full_q;
  logic [7:0] w_data_q;
  logic w_lane_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [7:0] rdata_q;
  logic [1:0] rresp_q;

  // ----------------------------------------------------------------
  // Divider, selector and interrupt state
  // ----------------------------------------------------------------
  logic [RTC_DIV_STAGES-1:0] taps;
  logic running;
  logic [4:0] tap_idx;
  logic tap_now;
  logic tap_q;
  logic sec_q;
  logic sec_rise;
  logic rate_on;
  logic [2:0] ev_vec;
  logic [2:0] clr_vec;
  logic [2:0] flags;
  logic sqw_q;
  logic uip_q;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic [5:0] widx;
  logic wr_ok;
  logic wr_mem;
  logic rd_fire;
  logic [5:0] ridx;
  logic rd_ok;
  logic rd_is_c;
  logic [7:0] rd_byte;

  // Control fields of registers A and B.
  assign rate_select = reg_a_q[3:0];
  assign divider_select = reg_a_q[6:4];
  assign update_hold = reg_b_q[RTC_BIT_TOP];
  assign src_enable = reg_b_q[RTC_SRC_LSB+2:RTC_SRC_LSB];
  assign square_wave_enable = reg_b_q[RTC_B_SQUARE_WAVE_ENABLE];

  // Write channels are taken independently and held until both are present.
  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign wr_fire = aw_full_q && w_full_q;
  assign widx = aw_addr_q[7:2];
  assign wr_ok = (aw_addr_q[31:8] == 24'h000000);

  // Indexes A to D are kept out of the array, and C and D are never written; every other index is storage.
  assign wr_mem = wr_fire && wr_ok && w_lane_q && (widx != RTC_IDX_A) &&
                  (widx != RTC_IDX_B) && (widx != RTC_IDX_C) &&
                  (widx != RTC_IDX_D);

  // Read decode; one read at a time, the data held until taken.
  assign s_axi_arready = !rvalid_q;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign ridx = s_axi_araddr[7:2];
  assign rd_ok = (s_axi_araddr[31:8] == 24'h000000);
  assign rd_is_c = rd_fire && rd_ok && (ridx == RTC_IDX_C);

  // Read multiplexer; read-only bits come from live state, D reads zero.
  assign rd_byte = !rd_ok ? 8'h00 :
                   (ridx == RTC_IDX_A) ? {uip_q, reg_a_q} :
                   (ridx == RTC_IDX_B) ? reg_b_q :
                   (ridx == RTC_IDX_C) ? {~irq_n, flags, 4'h0} :
                   (ridx == RTC_IDX_D) ? 8'h00 :
                   (ridx == RTC_IDX_SEC) ? {1'b0, mem_q[ridx][6:0]} :
                   mem_q[ridx];

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------

  // Address and data holding registers and the write response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 32'h00000000;
      w_full_q <= 1'b0;
      w_data_q <= 8'h00;
      w_lane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RTC_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full_q <= 1'b0;
      end
      if (w_take) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_lane_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_full_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RTC_RESP_OKAY : RTC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Control registers; bit 7 of A is status and is not stored.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reg_a_q <= RTC_A_RESET[6:0];
      reg_b_q <= RTC_B_RESET;
    end else if (wr_fire && wr_ok && w_lane_q) begin
      if (widx == RTC_IDX_A) begin
        reg_a_q <= w_data_q[6:0];
      end
      if (widx == RTC_IDX_B) begin
        reg_b_q <= w_data_q;
      end
    end
  end

  // User and time bytes; the array needs no reset.
  always_ff @(posedge aclk) begin
    if (wr_mem) begin
      mem_q[widx] <= w_data_q;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // The byte is captured at the address edge, so flags are stable for the read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 8'h00;
      rresp_q <= RTC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_byte;
      rresp_q <= rd_ok ? RTC_RESP_OKAY : RTC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = {24'h000000, rdata_q};
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------------------------------
  // Divider chain and tap selector
  // ----------------------------------------------------------------

  rtc_divider #(
    .STAGES(RTC_DIV_STAGES)
  ) u_divider (
    .aclk(aclk),
    .aresetn(aresetn),
    .time_base_tick(time_base_tick),
    .divider_select(divider_select),
    .taps(taps),
    .running(running)
  );

  // The slow base has no low taps, so its two fastest codes use higher ones.
  assign tap_idx = ((divider_select == RTC_DV_32K) && (rate_select <= RTC_RS_LOW_32K_MAX)) ?
                   5'(rate_select) + RTC_TAP_BASE_32K :
                   5'(rate_select) + RTC_TAP_BASE;
  assign tap_now = taps[tap_idx];
  assign rate_on = running && (rate_select != 4'h0);

  // The chain starts from zero, so its top stage first rises after half a second.
  assign sec_rise = taps[RTC_DIV_STAGES-1] && !sec_q;

  // Event sources; hold stops updates but never the periodic tick.
  assign ev_vec[RTC_SRC_PER] = rate_on && tap_now && !tap_q;
  assign ev_vec[RTC_SRC_ALM] = alarm_match;
  assign ev_vec[RTC_SRC_UPD] = running && sec_rise && !update_hold;

  // Edge history, square wave and update status.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tap_q <= 1'b0;
      sec_q <= 1'b0;
      sqw_q <= 1'b0;
      uip_q <= 1'b0;
    end else begin
      tap_q <= tap_now;
      sec_q <= taps[RTC_DIV_STAGES-1];
      sqw_q <= square_wave_enable && rate_on && tap_now;
      uip_q <= ev_vec[RTC_SRC_UPD];
    end
  end

  assign square_wave_out = sqw_q;
  assign update_in_progress = uip_q;

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------

  // A read of C clears exactly the flags it returned.
  assign clr_vec = rd_is_c ? flags : 3'h0;

  rtc_irq_flags #(
    .N(3)
  ) u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(ev_vec),
    .clr(clr_vec),
    .en(src_enable),
    .flags(flags),
    .irq_n(irq_n)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  chk_read_clear:
    assert property (@(posedge aclk) disable iff (!aresetn)
      rd_is_c |=> ((flags & $past(flags) & ~$past(ev_vec)) == 3'h0))
    else $error("Flag read from C was not cleared.");

  chk_read_keep:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (rd_is_c && (ev_vec != 3'h0)) |=> ((flags & $past(ev_vec)) == $past(ev_vec)))
    else $error("Event during a C read was lost.");

  chk_any_interrupt_flag_bit:
    assert property (@(posedge aclk) disable iff (!aresetn)
      rd_is_c |=> (s_axi_rdata[7] == !$past(irq_n)))
    else $error("Summary bit does not match the request pin.");

  chk_enable_now:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_fire && wr_ok && w_lane_q && (widx == RTC_IDX_B) && !rd_is_c &&
       ((w_data_q[6:4] & flags) != 3'h0)) |=> !irq_n)
    else $error("Enable of a set flag did not raise the request.");

  chk_sqw_off:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (rate_select == 4'h0) |=> !square_wave_out)
    else $error("Square wave active with rate code zero.");

  chk_reset_quiet:
    assert property (@(posedge aclk) disable iff (!aresetn)
      rtc_dv_is_reset(divider_select) |-> !ev_vec[RTC_SRC_PER] ##1 !square_wave_out)
    else $error("Periodic tick or square wave during divider reset.");

  chk_update_hold:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (update_hold || !running) |-> !ev_vec[RTC_SRC_UPD])
    else $error("Update event while held or stopped.");

  chk_seconds_top:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (rd_fire && rd_ok && (ridx == RTC_IDX_SEC || ridx == RTC_IDX_D)) |=>
        !s_axi_rdata[7])
    else $error("Non-storage bit read back as one.");

  chk_write_resp:
    assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid)
    else $error("Write response missing after both channels.");
endmodule

// [verilog/rtc_pkg.sv]
// Package of constants and helpers for the clock interrupt, divider and square-wave block.
package rtc_pkg;
  // Register indexes; byte address is four times the index.
  localparam logic [5:0] RTC_IDX_SEC = 6'h00;
  localparam logic [5:0] RTC_IDX_A = 6'h0A;
  localparam logic [5:0] RTC_IDX_B = 6'h0B;
  localparam logic [5:0] RTC_IDX_C = 6'h0C;
  localparam logic [5:0] RTC_IDX_D = 6'h0D;
  localparam int RTC_NUM_LOC = 64;
  localparam int RTC_DIV_STAGES = 22;
  // Divider select codes and bypass counts.
  localparam logic [2:0] RTC_DV_4M = 3'h0;
  localparam logic [2:0] RTC_DV_1M = 3'h1;
  localparam logic [2:0] RTC_DV_32K = 3'h2;
  localparam logic [2:0] RTC_DV_RST0 = 3'h6;
  localparam logic [2:0] RTC_DV_RST1 = 3'h7;
  localparam int RTC_BYP_1M = 2;
  localparam int RTC_BYP_32K = 7;
  // Tap offsets for the rate selector.
  localparam logic [4:0] RTC_TAP_BASE = 5'h05;
  localparam logic [4:0] RTC_TAP_BASE_32K = 5'h0C;
  localparam logic [3:0] RTC_RS_LOW_32K_MAX = 4'h2;
  // Field positions: flags in C[6:4], enables in B[6:4] as periodic, alarm, update.
  localparam int RTC_BIT_TOP = 7;
  localparam int RTC_SRC_LSB = 4;
  localparam int RTC_B_SQUARE_WAVE_ENABLE = 3;
  localparam int RTC_SRC_UPD = 0;
  localparam int RTC_SRC_ALM = 1;
  localparam int RTC_SRC_PER = 2;
  // Reset values: divider held in reset, everything disabled.
  localparam logic [7:0] RTC_A_RESET = 8'h60;
  localparam logic [7:0] RTC_B_RESET = 8'h00;
  localparam logic [1:0] RTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RTC_RESP_SLVERR = 2'h2;

  // True for the two codes that hold the chain in reset.
  function automatic logic rtc_dv_is_reset(input logic [2:0] dv);
    return (dv == RTC_DV_RST0) || (dv == RTC_DV_RST1);
  endfunction

  // True for the three operating time-base codes.
  function automatic logic rtc_dv_is_run(input logic [2:0] dv);
    return (dv == RTC_DV_4M) || (dv == RTC_DV_1M) || (dv == RTC_DV_32K);
  endfunction
endpackage

// [verilog/rtc_divider.sv]
// Binary divider chain with time-base bypass and reset codes.
`timescale 1ns/10ps
module rtc_divider #(
  parameter int STAGES = 22
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Time base and control.
  input wire logic time_base_tick,
  input wire logic [2:0] divider_select,
  // Divider state.
  output logic [STAGES-1:0] taps,
  output logic running
);
  import rtc_pkg::*;

  logic [STAGES-1:0] cnt_q;
  logic [STAGES-1:0] cnt_d;
  logic [STAGES-1:0] step;
  logic clear;

  // Bypassing stages means adding one at a higher stage of the chain.
  assign clear = rtc_dv_is_reset(divider_select);
  assign running = rtc_dv_is_run(divider_select);
  assign step = (divider_select == RTC_DV_1M) ? (STAGES'(1) << RTC_BYP_1M) :
                (divider_select == RTC_DV_32K) ? (STAGES'(1) << RTC_BYP_32K) :
                STAGES'(1);
  assign cnt_d = clear ? '0 : (running && time_base_tick) ? cnt_q + step : cnt_q;
  assign taps = cnt_q;

  // Chain counter; test codes freeze it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  chk_div_clear:
    assert property (@(posedge aclk) disable iff (!aresetn)
      rtc_dv_is_reset(divider_select) |=> (taps == '0))
    else $error("Divider chain not cleared by reset code.");
endmodule

// [verilog/rtc_irq_flags.sv]
// Sticky interrupt flags, enable gating and the active-low request.
`timescale 1ns/10ps
module rtc_irq_flags #(
  parameter int N = 3
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Events, clears and enables.
  input wire logic [N-1:0] set,
  input wire logic [N-1:0] clr,
  input wire logic [N-1:0] en,
  // Flag state and request.
  output logic [N-1:0] flags,
  output logic irq_n
);
  import rtc_pkg::*;

  logic [N-1:0] flag_q;

  // Each flag sets on its event regardless of enable; a set beats a clear.
  for (genvar i = 0; i < N; i++) begin : g_flag
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flag_q[i] <= 1'b0;
      end else begin
        flag_q[i] <= set[i] | (flag_q[i] & ~clr[i]);
      end
    end
  end

  // Request is low while any flag meets its enable.
  assign flags = flag_q;
  assign irq_n = ~|(flag_q & en);

  chk_flag_set:
    assert property (@(posedge aclk) disable iff (!aresetn)
      (set != '0) |=> ((flags & $past(set)) == $past(set)))
    else $error("Event did not set its flag.");

  chk_irq_level:
    assert property (@(posedge aclk) disable iff (!aresetn)
      ((flags & en) != '0) |-> !irq_n)
    else $error("Request not asserted with flag and enable set.");
endmodule

// [test/rtc_tb_source.sv]
// Model of the time-base oscillator and the alarm comparator feeding the clock block.
`timescale 1ns/10ps
module rtc_tb_source (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Requests from the bench.
  input wire logic [31:0] tick_goal,
  input wire logic alarm_req,
  // Signals toward the block, and the tick count back to the bench.
  output logic time_base_tick,
  output logic alarm_match,
  output logic [31:0] tick_total
);
  // One tick every other cycle until the requested total is reached; the base stays quiet after.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      time_base_tick <= 1'b0;
      tick_total <= 32'h0;
      alarm_match <= 1'b0;
    end else begin
      time_base_tick <= !time_base_tick && (tick_total < tick_goal);
      if (!time_base_tick && (tick_total < tick_goal)) begin
        tick_total <= tick_total + 32'h1;
      end
      alarm_match <= alarm_req;
    end
  end
endmodule

// [test/rtc_interrupt_divider_squarewave_tb_top.sv]
// Self-checking bench for the clock block: registers, flags, divider and square wave.
`timescale 1ns/10ps
module rtc_interrupt_divider_squarewave_tb_top;
  import rtc_pkg::*;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, tick_goal, tick_total;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic time_base_tick, alarm_match, alarm_req, irq_n, square_wave_out, update_in_progress;
  logic [33:0] exp_q[$];
  logic [7:0] a_val[5] = '{8'h01, 8'h11, 8'h00, 8'h21, 8'h61};
  logic [7:0] b_val[5] = '{8'h08, 8'h88, 8'h08, 8'h08, 8'h08};
  logic [7:0] c_val[5] = '{8'h40, 8'h40, 8'h00, 8'h40, 8'h00};
  logic [5:0] ram_idx[3] = '{6'h05, 6'h0E, 6'h3F};
  logic [7:0] d;
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;
  int sqw_hi = 0;
  int upd_pulses = 0;
  int seed;

  rtc_core dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .time_base_tick(time_base_tick), .alarm_match(alarm_match),
    .irq_n(irq_n), .square_wave_out(square_wave_out),
    .update_in_progress(update_in_progress));

  rtc_tb_source source (.aclk(aclk), .aresetn(aresetn), .tick_goal(tick_goal),
    .alarm_req(alarm_req), .time_base_tick(time_base_tick), .alarm_match(alarm_match),
    .tick_total(tick_total));

  // ---------------------------------------------------------------
  // Clock, timeout and verdict.
  // ---------------------------------------------------------------
  always #5 aclk = ~aclk;

  // A hang is cut short well after the longest expected run.
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 50000) begin
      mismatches++;
      results();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic results;
    $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Compares one observed value with its expectation.
  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ---------------------------------------------------------------
  // Bus master tasks and response watcher.
  // ---------------------------------------------------------------
  // Handshakes are judged at the falling edge, where inputs and ready are settled.
  always @(negedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    if (s_axi_bvalid && s_axi_bready)
      chk("write", {s_axi_bresp, 32'h0}, exp_q.pop_front());
    if (square_wave_out)
      sqw_hi++;
    if (update_in_progress)
      upd_pulses++;
  end

  // Byte address of a register index.
  function automatic logic [31:0] adr(input logic [5:0] idx);
    return {24'h0, idx, 2'b00};
  endfunction

  // One write; address and data are offered together and released as each is taken.
  task automatic wr(input logic [31:0] a, input logic [7:0] v, input logic [1:0] r);
    logic aw, w, done;
    exp_q.push_back({r, 32'h0});
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= {24'h0, v};
    s_axi_bready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (done) s_axi_bready <= 1'b0;
    end
  endtask

  // One read; the expected response and byte are noted for the watcher.
  task automatic rd(input logic [31:0] a, input logic [1:0] r, input logic [7:0] v);
    logic ar, done;
    exp_q.push_back({r, 24'h0, v});
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      if (done) s_axi_rready <= 1'b0;
    end
  endtask

  // Asks the time base for n more ticks and waits until they have been given.
  task automatic run_ticks(input int n);
    @(posedge aclk);
    tick_goal <= tick_goal + n;
    @(negedge aclk);
    while (tick_total != tick_goal)
      @(negedge aclk);
  endtask

  // One alarm comparator pulse, then time for the flag to settle.
  task automatic pulse_alarm;
    @(posedge aclk);
    alarm_req <= 1'b1;
    @(posedge aclk);
    alarm_req <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h5c8ed694;
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
    {s_axi_arvalid, s_axi_rready, alarm_req} = 3'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, tick_goal} = 128'h0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values and the places that are not storage.
    rd(adr(RTC_IDX_A), RTC_RESP_OKAY, RTC_A_RESET);
    rd(adr(RTC_IDX_B), RTC_RESP_OKAY, RTC_B_RESET);
    rd(adr(RTC_IDX_D), RTC_RESP_OKAY, 8'h00);
    wr(adr(RTC_IDX_A), 8'hE0, RTC_RESP_OKAY);
    rd(adr(RTC_IDX_A), RTC_RESP_OKAY, 8'h60);
    wr(adr(RTC_IDX_C), 8'hFF, RTC_RESP_OKAY);
    rd(adr(RTC_IDX_C), RTC_RESP_OKAY, 8'h00);
    wr(adr(RTC_IDX_SEC), 8'hFF, RTC_RESP_OKAY);
    rd(adr(RTC_IDX_SEC), RTC_RESP_OKAY, 8'h7F);
    // A time byte and user RAM at both ends hold random bytes.
    foreach (ram_idx[i]) begin
      d = 8'($random(seed));
      wr(adr(ram_idx[i]), d, RTC_RESP_OKAY);
      rd(adr(ram_idx[i]), RTC_RESP_OKAY, d);
    end
    wr(32'h100, 8'h55, RTC_RESP_SLVERR);
    rd(32'h100, RTC_RESP_SLVERR, 8'h00);
    // A write with byte lane 0 switched off stores nothing.
    s_axi_wstrb <= 4'hE;
    wr(adr(6'h3F), 8'h00, RTC_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(adr(6'h3F), RTC_RESP_OKAY, d);
    // Alarm flag without enable, clear on read, then late enabling.
    pulse_alarm();
    @(negedge aclk);
    chk("irq_n", {33'h0, irq_n}, 34'h1);
    rd(adr(RTC_IDX_C), RTC_RESP_OKAY, 8'h20);
    rd(adr(RTC_IDX_C), RTC_RESP_OKAY, 8'h00);
    // An alarm event that lands on the read edge is kept for the next read.
    fork
      pulse_alarm();
      begin
        @(posedge aclk);
        rd(adr(RTC_IDX_C), RTC_RESP_OKAY, 8'h00);
      end
    join
    rd(adr(RTC_IDX_C), RTC_RESP_OKAY, 8'h20);
    pulse_alarm();
    wr(adr(RTC_IDX_B), 8'h20, RTC_RESP_OKAY);
    @(negedge aclk);
    chk("irq_n", {33'h0, irq_n}, 34'h0);
    rd(adr(RTC_IDX_C), RTC_RESP_OKAY, 8'hA0);
    @(negedge aclk);
    chk("irq_n", {33'h0, irq_n}, 34'h1);
    wr(adr(RTC_IDX_B), 8'h00, RTC_RESP_OKAY);
    // Rate tap with square wave: running, under hold, rate zero, divider in reset.
    foreach (a_val[i]) begin
      wr(adr(RTC_IDX_B), b_val[i], RTC_RESP_OKAY);
      wr(adr(RTC_IDX_A), a_val[i], RTC_RESP_OKAY);
      sqw_hi = 0;
      run_ticks(200);
      rd(adr(RTC_IDX_C), RTC_RESP_OKAY, c_val[i]);
      chk("square wave", {33'h0, sqw_hi != 0}, {33'h0, c_val[i] != 8'h00});
    end
    // First update half a second after leaving reset on the slow base.
    wr(adr(RTC_IDX_B), 8'h00, RTC_RESP_OKAY);
    rd(adr(RTC_IDX_C), RTC_RESP_OKAY, 8'h00);
    wr(adr(RTC_IDX_A), 8'h20, RTC_RESP_OKAY);
    upd_pulses = 0;
    run_ticks(16383);
    rd(adr(RTC_IDX_C), RTC_RESP_OKAY, 8'h00);
    run_ticks(1);
    repeat (3) @(posedge aclk);
    rd(adr(RTC_IDX_C), RTC_RESP_OKAY, 8'h10);
    chk("update pulses", 34'(upd_pulses), 34'h1);
    results();
  end
endmodule
